/* File: verilog/sbst_pkg.sv */
// sbst_pkg: constants and state type of the serial bus telegram slave
// assumes a 100 MHz mclk and 7-bit ASCII characters on the bus
//
// Contract
// - bit rate 300 to 9600, chosen by switch
// - frame: start, seven data, parity, stop
// - half duplex, but NAK may overlap master
// - never transmits unless addressed and asked
// - answers only own station number 0..31
// - switches set locally, never by telegram
// - STX, station, data, ETX, optional checksum
// - fault-free request answered at once, same format
// - status scan: code bit, two status bytes
// - mode 0 none, 1 parameters, 2 remote too
// - 32-byte receive buffer checked before use; a refused telegram still overwrites words awaiting apply
// - received values applied at next cycle start
// - parameter changes committed to non-volatile storage
// - process data staged at end of cycle
// - traffic timeout clears remote computer standby
package sbst_pkg;
  localparam logic [6:0] CHAR_STX        = 7'h02;
  localparam logic [6:0] CHAR_ETX        = 7'h03;
  localparam logic [6:0] CHAR_NAK        = 7'h15;
  localparam logic [6:0] CHAR_DIG0       = 7'h30;
  localparam logic [6:0] CHAR_DIG9       = 7'h39;
  localparam logic [6:0] CHAR_HEXA       = 7'h41;
  localparam logic [6:0] CHAR_HEXF       = 7'h46;
  localparam logic [6:0] HEX_LETTER_OFS  = 7'h37;
  localparam logic [3:0] HEX_LETTER_ADJ  = 4'h9;
  localparam logic [1:0] STN_MARK        = 2'h2;
  localparam int         STN_MARK_BIT    = 6;
  localparam int         SCAN_BIT        = 5;
  localparam int         CTRL_READ_BIT   = 5;
  localparam int         CTRL_MARK_BIT   = 6;
  localparam logic [5:0] HDR_BYTES       = 6'h03;
  localparam logic [5:0] RXBUF_BYTES     = 6'h20;
  localparam logic [3:0] MAX_WORDS       = 4'h7;
  localparam logic [7:0] ADDR_PARAM_LAST = 8'h5f;
  localparam logic [7:0] ADDR_REM_STATUS = 8'h65;
  localparam logic [7:0] ADDR_REM_OUTPUT = 8'h67;
  localparam logic [7:0] ADDR_STAGE_BASE = 8'h68;
  localparam int         STAGE_AW        = 5;
  localparam int         CB_BIT          = 7;
  localparam logic [1:0] MODE_TX_ONLY    = 2'h0;
  localparam logic [1:0] MODE_PARAM      = 2'h1;
  localparam logic [1:0] MODE_REMOTE     = 2'h2;
  localparam logic       PARITY_ODD      = 1'b0;
  localparam logic [3:0] FRAME_LAST      = 4'h9;
  localparam logic [2:0] BAUD_STEPS      = 3'h5;
  localparam int         CLK_HZ          = 100_000_000;
  localparam int         BAUD_MAX_BPS    = 9600;
  localparam int         BIT_CYCLES_FAST = CLK_HZ / BAUD_MAX_BPS;
  localparam int         TIMEOUT_MS      = 1000;
  localparam int         TIMEOUT_CYCLES  = TIMEOUT_MS * (CLK_HZ / 1000);

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_STN    = 7'h02,
    S_BODY   = 7'h04,
    S_BCC    = 7'h08,
    S_DECODE = 7'h10,
    S_REPLY  = 7'h20,
    S_SKIP   = 7'h40
  } sbst_state_type;
endpackage

/* File: verilog/sbst_char_uart.sv */
// sbst_char_uart: one-character transceiver, 7 data bits plus parity
// assumes rxdPin is raw from the line receiver; txStart is a mclk pulse
`timescale 1ns/1ps
module sbst_char_uart #(
  parameter int BIT_CYCLES = sbst_pkg::BIT_CYCLES_FAST
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [2:0] baudSelect,
  input  wire logic       rxdPin,
  output logic            rxValid,
  output logic [6:0]      rxChar,
  output logic            rxErr,
  input  wire logic       txStart,
  input  wire logic [6:0] txChar,
  output logic            txBusy,
  output logic            txdPin
);
  import sbst_pkg::*;
  localparam int CW = $clog2(BIT_CYCLES * 32 + 1);

  logic [CW-1:0] bitLen;
  logic [2:0]    shiftAmt;
  logic          rxMeta_q, rxSync_q;
  logic          rxAct_q, rxAct_d, rxValid_q, rxValid_d, rxErr_q, rxErr_d;
  logic [CW-1:0] rxCnt_q, rxCnt_d, txCnt_q, txCnt_d;
  logic [3:0]    rxBit_q, rxBit_d, txBit_q, txBit_d;
  logic [7:0]    rxSh_q, rxSh_d;
  logic [6:0]    rxChar_q, rxChar_d;
  logic          txAct_q, txAct_d, txd_q, txd_d;
  logic [9:0]    txSh_q, txSh_d;

  // slowest rate is the fastest one halved five times
  assign shiftAmt = (baudSelect > BAUD_STEPS) ? 3'h0 : BAUD_STEPS - baudSelect;
  assign bitLen   = CW'(BIT_CYCLES) << shiftAmt;
  assign rxValid  = rxValid_q;
  assign rxChar   = rxChar_q;
  assign rxErr    = rxErr_q;
  assign txBusy   = txAct_q;
  assign txdPin   = txd_q;

  always_comb begin
    rxAct_d   = rxAct_q;
    rxCnt_d   = rxCnt_q;
    rxBit_d   = rxBit_q;
    rxSh_d    = rxSh_q;
    rxValid_d = 1'b0;
    rxErr_d   = rxErr_q;
    rxChar_d  = rxChar_q;
    if (!rxAct_q) begin
      if (!rxSync_q) begin
        rxAct_d = 1'b1;
        rxCnt_d = bitLen >> 1;
        rxBit_d = 4'h0;
      end
    end else if (rxCnt_q != '0) begin
      rxCnt_d = rxCnt_q - 1'b1;
    end else begin
      rxCnt_d = bitLen - 1'b1;
      rxBit_d = rxBit_q + 4'h1;
      if (rxBit_q == 4'h0) begin
        // a glitch shorter than half a bit is not a start bit
        rxAct_d = !rxSync_q;
      end else if (rxBit_q == FRAME_LAST) begin
        rxAct_d   = 1'b0;
        rxValid_d = 1'b1;
        rxChar_d  = rxSh_q[6:0];
        rxErr_d   = !rxSync_q || ((^rxSh_q) != PARITY_ODD);
      end else begin
        rxSh_d = {rxSync_q, rxSh_q[7:1]};
      end
    end
  end

  always_comb begin
    txAct_d = txAct_q;
    txSh_d  = txSh_q;
    txCnt_d = txCnt_q;
    txBit_d = txBit_q;
    if (!txAct_q) begin
      if (txStart) begin
        txAct_d = 1'b1;
        txSh_d  = {1'b1, (^txChar) ^ PARITY_ODD, txChar, 1'b0};
        txCnt_d = bitLen - 1'b1;
        txBit_d = 4'h0;
      end
    end else if (txCnt_q != '0) begin
      txCnt_d = txCnt_q - 1'b1;
    end else begin
      txSh_d  = {1'b1, txSh_q[9:1]};
      txCnt_d = bitLen - 1'b1;
      txBit_d = txBit_q + 4'h1;
      txAct_d = (txBit_q != FRAME_LAST);
    end
    txd_d = txAct_d ? txSh_d[0] : 1'b1;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxMeta_q  <= 1'b1;
      rxSync_q  <= 1'b1;
      rxAct_q   <= 1'b0;
      rxCnt_q   <= '0;
      rxBit_q   <= 4'h0;
      rxSh_q    <= 8'h00;
      rxValid_q <= 1'b0;
      rxErr_q   <= 1'b0;
      rxChar_q  <= 7'h00;
      txAct_q   <= 1'b0;
      txSh_q    <= 10'h3ff;
      txCnt_q   <= '0;
      txBit_q   <= 4'h0;
      txd_q     <= 1'b1;
    end else begin
      rxMeta_q  <= rxdPin;
      rxSync_q  <= rxMeta_q;
      rxAct_q   <= rxAct_d;
      rxCnt_q   <= rxCnt_d;
      rxBit_q   <= rxBit_d;
      rxSh_q    <= rxSh_d;
      rxValid_q <= rxValid_d;
      rxErr_q   <= rxErr_d;
      rxChar_q  <= rxChar_d;
      txAct_q   <= txAct_d;
      txSh_q    <= txSh_d;
      txCnt_q   <= txCnt_d;
      txBit_q   <= txBit_d;
      txd_q     <= txd_d;
    end
  end
endmodule

/* File: verilog/sbst_telegram_slave.sv */
// sbst_telegram_slave: passive station on a multi-drop ASCII telegram bus
// assumes switch pins and standbyInput are asynchronous; cycle strobes,
// staging writes and parameter reads come from logic on mclk
`timescale 1ns/1ps
module sbst_telegram_slave #(
  parameter int BIT_CYCLES     = sbst_pkg::BIT_CYCLES_FAST,
  parameter int TIMEOUT_CYCLES = sbst_pkg::TIMEOUT_CYCLES,
  parameter int STAGE_AW       = sbst_pkg::STAGE_AW
) (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                rxdPin,
  output logic                     txdPin,
  output logic                     txdDrive,
  input  wire logic [2:0]          baudSelectSwitch,
  input  wire logic [1:0]          interfaceModeSwitch,
  input  wire logic [4:0]          stationNumberSwitch,
  input  wire logic                timeoutSelectSwitch,
  input  wire logic                checksumSwitch,
  input  wire logic                standbyInput,
  input  wire logic [6:0]          statusByteOne,
  input  wire logic [6:0]          statusByteTwo,
  input  wire logic                cycleStart,
  input  wire logic                cycleEnd,
  input  wire logic                stageWrValid,
  input  wire logic [STAGE_AW-1:0] stageWrAddr,
  input  wire logic [15:0]         stageWrData,
  output logic [7:0]               paramRdAddr,
  input  wire logic [15:0]         paramRdData,
  output logic                     applyValid,
  output logic [7:0]               applyAddr,
  output logic [15:0]              applyData,
  output logic                     nvCommit,
  output logic                     computerStandby,
  output logic                     remoteComputerStandby
);
  import sbst_pkg::*;
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  logic [12:0]    swMeta_q, swSync_q;
  logic [1:0]     swMode;
  logic [4:0]     swStn;
  logic [2:0]     swBaud;
  logic           swTo, swCk, swCb;
  logic           rxValid, rxErr, txStart, txBusy;
  logic [6:0]     rxChar, txChar;
  sbst_state_type state_q, state_d;
  logic [5:0]     len_q, len_d, idx_q, idx_d, repK_q, repK_d, pos, bodyLen, lastK;
  logic [6:0]     bcc_q, bcc_d, txBcc_q, txBcc_d, ctrl_q, ctrl_d, bufChar;
  logic           err_q, err_d, scan_q, scan_d, nak_q, nak_d;
  logic [7:0]     base_q, base_d, rdAddr, stageOff;
  logic [15:0]    acc_q, acc_d, rdWord, rdShift;
  logic [4:0]     hv;
  logic [3:0]     cnt;
  logic           bufWe, wordWe, finalize, bad, pendSet, msgOk, cbWrite;
  logic [6:0]     rxBuf [0:31];
  logic [15:0]    words [0:7];
  logic [15:0]    stage [0:(2 << STAGE_AW) - 1];
  logic           bank_q, pend_q, pend_d, applying_q, applying_d, remCb_q, remCb_d;
  logic [2:0]     aIdx_q, aIdx_d;
  logic [3:0]     aCnt_q, aCnt_d;
  logic [7:0]     aBase_q, aBase_d, applyAddr_q, applyAddr_d;
  logic [15:0]    applyData_q, applyData_d;
  logic           applyValid_q, applyValid_d, nvCommit_q, nvCommit_d, cbOut_q;
  logic [TW-1:0]  toCnt_q, toCnt_d;

  function automatic logic [4:0] hexVal(input logic [6:0] c);
    if (c >= CHAR_DIG0 && c <= CHAR_DIG9) hexVal = {1'b1, c[3:0]};
    else if (c >= CHAR_HEXA && c <= CHAR_HEXF) hexVal = {1'b1, c[3:0] + HEX_LETTER_ADJ};
    else hexVal = 5'h00;
  endfunction

  function automatic logic [6:0] hexChar(input logic [3:0] n);
    hexChar = (n > HEX_LETTER_ADJ) ? {3'h0, n} + HEX_LETTER_OFS : {3'h0, n} + CHAR_DIG0;
  endfunction

  // what each interface mode lets a telegram write
  function automatic logic writeAllowed(input logic [1:0] m, input logic [7:0] a);
    writeAllowed = ((m == MODE_PARAM || m == MODE_REMOTE) && a <= ADDR_PARAM_LAST)
                || (m == MODE_REMOTE && a >= ADDR_REM_STATUS && a <= ADDR_REM_OUTPUT);
  endfunction

  // switches are read only through this synchroniser; no telegram path writes them
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      swMeta_q <= 13'h0000;
      swSync_q <= 13'h0000;
    end else begin
      swMeta_q <= {interfaceModeSwitch, stationNumberSwitch, baudSelectSwitch,
                   timeoutSelectSwitch, checksumSwitch, standbyInput};
      swSync_q <= swMeta_q;
    end
  end
  assign {swMode, swStn, swBaud, swTo, swCk, swCb} = swSync_q;

  sbst_char_uart #(.BIT_CYCLES(BIT_CYCLES)) uart (
    .mclk       (mclk),
    .nrst       (nrst),
    .baudSelect (swBaud),
    .rxdPin     (rxdPin),
    .rxValid    (rxValid),
    .rxChar     (rxChar),
    .rxErr      (rxErr),
    .txStart    (txStart),
    .txChar     (txChar),
    .txBusy     (txBusy),
    .txdPin     (txdPin)
  );
  assign txdDrive = txBusy;

  // read source: staged process data in the 32 words from the stage base on, live parameters elsewhere
  // a reply steps through the read words by character, decoding by buffer byte
  assign pos      = (state_q == S_REPLY) ? repK_q - 6'h02 : idx_q - HDR_BYTES;
  assign bufChar  = rxBuf[idx_q[4:0]];
  assign hv       = hexVal(bufChar);
  assign cnt      = ctrl_q[3:0];
  assign rdAddr   = base_q + {5'h00, pos[4:2]};
  assign stageOff = rdAddr - ADDR_STAGE_BASE;
  assign paramRdAddr = rdAddr;
  assign rdWord   = (rdAddr >= ADDR_STAGE_BASE && stageOff < 8'(1 << STAGE_AW))
                  ? stage[{bank_q, stageOff[STAGE_AW-1:0]}] : paramRdData;
  assign rdShift  = rdWord >> {~pos[1:0], 2'b00};
  assign bodyLen  = nak_q ? 6'h00 : scan_q ? 6'h02
                  : ctrl_q[CTRL_READ_BIT] ? {cnt, 2'b00} : 6'h00;
  assign lastK    = nak_q ? 6'h00 : bodyLen + 6'h02 + {5'h00, swCk};

  always_comb begin
    if (nak_q) txChar = CHAR_NAK;
    else if (repK_q == 6'h00) txChar = CHAR_STX;
    else if (repK_q == 6'h01) txChar = {STN_MARK, swStn};
    else if (repK_q < bodyLen + 6'h02) begin
      if (scan_q) txChar = (repK_q == 6'h02) ? statusByteOne : statusByteTwo;
      else txChar = hexChar(rdShift[3:0]);
    end else if (repK_q == bodyLen + 6'h02) txChar = CHAR_ETX;
    else txChar = txBcc_q;
  end

  always_comb begin
    state_d  = state_q;
    len_d    = len_q;
    idx_d    = idx_q;
    bcc_d    = bcc_q;
    err_d    = err_q;
    scan_d   = scan_q;
    nak_d    = nak_q;
    ctrl_d   = ctrl_q;
    base_d   = base_q;
    acc_d    = acc_q;
    repK_d   = repK_q;
    txBcc_d  = txBcc_q;
    bufWe    = 1'b0;
    wordWe   = 1'b0;
    finalize = 1'b0;
    bad      = 1'b0;
    txStart  = 1'b0;
    case (state_q)
      S_IDLE, S_SKIP: begin
        if (rxValid && !rxErr && rxChar == CHAR_STX) begin
          state_d = S_STN;
          len_d   = 6'h00;
          err_d   = 1'b0;
        end
      end
      S_STN: begin
        if (rxValid) begin
          // a foreign or garbled address is not ours to answer
          if (!rxErr && rxChar[STN_MARK_BIT] && rxChar[4:0] == swStn) begin
            state_d = S_BODY;
            scan_d  = rxChar[SCAN_BIT];
            bcc_d   = rxChar;
          end else begin
            state_d = S_SKIP;
          end
        end
      end
      S_BODY: begin
        if (rxValid) begin
          if (rxErr) begin
            // reject at once, even while the master is still sending
            nak_d   = 1'b1;
            repK_d  = 6'h00;
            state_d = S_REPLY;
          end else if (rxChar == CHAR_ETX) begin
            bcc_d   = bcc_q ^ rxChar;
            idx_d   = 6'h00;
            state_d = swCk ? S_BCC : S_DECODE;
          end else if (len_q == RXBUF_BYTES) begin
            err_d = 1'b1;
          end else begin
            bufWe = 1'b1;
            len_d = len_q + 6'h01;
            bcc_d = bcc_q ^ rxChar;
          end
        end
      end
      S_BCC: begin
        if (rxValid) begin
          err_d   = err_q || rxErr || rxChar != bcc_q;
          state_d = S_DECODE;
        end
      end
      S_DECODE: begin
        if (!scan_q && idx_q < len_q) begin
          idx_d = idx_q + 6'h01;
          if (idx_q == 6'h00) begin
            ctrl_d = bufChar;
            err_d  = err_q || !bufChar[CTRL_MARK_BIT];
          end else begin
            err_d = err_q || !hv[4];
            if (idx_q == 6'h01) base_d[7:4] = hv[3:0];
            else if (idx_q == 6'h02) base_d[3:0] = hv[3:0];
            else begin
              acc_d  = {acc_q[11:0], hv[3:0]};
              wordWe = (pos[1:0] == 2'b11);
            end
          end
        end else begin
          finalize = 1'b1;
          if (scan_q) bad = err_q || len_q != 6'h00;
          else if (ctrl_q[CTRL_READ_BIT]) bad = err_q || len_q != HDR_BYTES;
          else bad = err_q || len_q != HDR_BYTES + {cnt, 2'b00} || pend_q || applying_q
                  || !writeAllowed(swMode, base_q)
                  || !writeAllowed(swMode, base_q + {4'h0, cnt} - 8'h01);
          bad     = bad || (!scan_q && (cnt == 4'h0 || cnt > MAX_WORDS));
          nak_d   = bad;
          repK_d  = 6'h00;
          txBcc_d = 7'h00;
          state_d = S_REPLY;
        end
      end
      S_REPLY: begin
        if (!txBusy) begin
          txStart = 1'b1;
          repK_d  = repK_q + 6'h01;
          if (repK_q != 6'h00) txBcc_d = txBcc_q ^ txChar;
          if (repK_q == lastK) begin
            state_d = S_IDLE;
            nak_d   = 1'b0;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  assign pendSet = finalize && !bad && !scan_q && !ctrl_q[CTRL_READ_BIT];
  assign msgOk   = finalize && !bad;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      len_q   <= 6'h00;
      idx_q   <= 6'h00;
      bcc_q   <= 7'h00;
      err_q   <= 1'b0;
      scan_q  <= 1'b0;
      nak_q   <= 1'b0;
      ctrl_q  <= 7'h00;
      base_q  <= 8'h00;
      acc_q   <= 16'h0000;
      repK_q  <= 6'h00;
      txBcc_q <= 7'h00;
    end else begin
      state_q <= state_d;
      len_q   <= len_d;
      idx_q   <= idx_d;
      bcc_q   <= bcc_d;
      err_q   <= err_d;
      scan_q  <= scan_d;
      nak_q   <= nak_d;
      ctrl_q  <= ctrl_d;
      base_q  <= base_d;
      acc_q   <= acc_d;
      repK_q  <= repK_d;
      txBcc_q <= txBcc_d;
    end
  end

  // memories carry no reset; rxBuf and words entries are written before read, a stage entry may be read unwritten
  always_ff @(posedge mclk) begin
    if (bufWe) rxBuf[len_q[4:0]] <= rxChar;
    if (wordWe) words[pos[4:2]] <= acc_d;
    if (stageWrValid) stage[{~bank_q, stageWrAddr}] <= stageWrData;
  end

  // received words reach the controller only from the next cycle start on
  always_comb begin
    pend_d       = pend_q || pendSet;
    applying_d   = applying_q;
    aIdx_d       = aIdx_q;
    aCnt_d       = aCnt_q;
    aBase_d      = aBase_q;
    applyValid_d = 1'b0;
    applyAddr_d  = applyAddr_q;
    applyData_d  = applyData_q;
    nvCommit_d   = 1'b0;
    remCb_d      = remCb_q;
    cbWrite      = 1'b0;
    toCnt_d      = toCnt_q + 1'b1;
    if (pendSet) begin
      aBase_d = base_q;
      aCnt_d  = cnt;
    end
    if (pend_q && !applying_q && cycleStart) begin
      pend_d     = 1'b0;
      applying_d = 1'b1;
      aIdx_d     = 3'h0;
    end
    if (applying_q) begin
      applyValid_d = 1'b1;
      applyAddr_d  = aBase_q + {5'h00, aIdx_q};
      applyData_d  = words[aIdx_q];
      nvCommit_d   = applyAddr_d <= ADDR_PARAM_LAST;
      aIdx_d       = aIdx_q + 3'h1;
      applying_d   = ({1'b0, aIdx_q} != aCnt_q - 4'h1);
      cbWrite      = applyAddr_d == ADDR_REM_STATUS;
    end
    if (!swTo || msgOk) toCnt_d = '0;
    else if (toCnt_q == TW'(TIMEOUT_CYCLES - 1)) begin
      toCnt_d = '0;
      remCb_d = 1'b0;
    end
    // a standby write in the same cycle wins over the timeout
    if (cbWrite) remCb_d = applyData_d[CB_BIT];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pend_q       <= 1'b0;
      applying_q   <= 1'b0;
      aIdx_q       <= 3'h0;
      aCnt_q       <= 4'h0;
      aBase_q      <= 8'h00;
      applyValid_q <= 1'b0;
      applyAddr_q  <= 8'h00;
      applyData_q  <= 16'h0000;
      nvCommit_q   <= 1'b0;
      remCb_q      <= 1'b0;
      toCnt_q      <= '0;
      bank_q       <= 1'b0;
      cbOut_q      <= 1'b0;
    end else begin
      pend_q       <= pend_d;
      applying_q   <= applying_d;
      aIdx_q       <= aIdx_d;
      aCnt_q       <= aCnt_d;
      aBase_q      <= aBase_d;
      applyValid_q <= applyValid_d;
      applyAddr_q  <= applyAddr_d;
      applyData_q  <= applyData_d;
      nvCommit_q   <= nvCommit_d;
      remCb_q      <= remCb_d;
      toCnt_q      <= toCnt_d;
      bank_q       <= bank_q ^ cycleEnd;
      cbOut_q      <= swCb || remCb_q;
    end
  end

  assign applyValid            = applyValid_q;
  assign applyAddr             = applyAddr_q;
  assign applyData             = applyData_q;
  assign nvCommit              = nvCommit_q;
  assign computerStandby       = cbOut_q;
  assign remoteComputerStandby = remCb_q;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence applyArmed;
    cycleStart && pend_q && !applying_q;
  endsequence
  sequence applyFirst;
    applyValid_q && applyAddr_q == aBase_q;
  endsequence

  tx_addressed_a: assert property (txStart |-> state_q == S_REPLY)
    else $error("transmit outside a reply");
  foreign_station_a: assert property (state_q == S_STN && rxValid && !rxErr
      && rxChar[4:0] != swStn |=> state_q == S_SKIP)
    else $error("answered a foreign station");
  mode_write_a: assert property (pendSet |-> swMode != MODE_TX_ONLY)
    else $error("write accepted in transmit-only mode");
  buf_bound_a: assert property (len_q <= RXBUF_BYTES)
    else $error("receive buffer overrun");
  apply_cycle_a: assert property (applyArmed |-> ##2 applyFirst)
    else $error("apply did not follow cycle start");
  apply_late_a: assert property ($rose(applyValid_q) |-> $past(cycleStart, 2))
    else $error("apply without a cycle start");
  nv_commit_a: assert property (nvCommit_q |-> applyValid_q && applyAddr_q <= ADDR_PARAM_LAST)
    else $error("commit for a non-parameter");
  stage_swap_a: assert property (cycleEnd |=> bank_q != $past(bank_q))
    else $error("staging bank did not swap");
  timeout_clear_a: assert property (swTo && !msgOk && !cbWrite
      && toCnt_q == TW'(TIMEOUT_CYCLES - 1) |=> !remCb_q ##1 computerStandby == $past(swCb))
    else $error("standby survived the timeout");
  nak_reply_a: assert property (finalize && bad |=> state_q == S_REPLY && nak_q)
    else $error("faulty message not refused");
  rx_nak_a: assert property (state_q == S_BODY && rxValid && rxErr |=> nak_q && txStart)
    else $error("no immediate refusal on a bad character");
  reply_stx_a: assert property (txStart && repK_q == 6'h00 && !nak_q |-> txChar == CHAR_STX)
    else $error("reply does not open with STX");
endmodule

/* File: testbench/sbst_master_model.sv */
// sbst_master_model: bus master that sends characters and collects replies
// assumes 8 mclk per bit; inputs change at the falling edge
`timescale 1ns/1ps
module sbst_master_model (
  input  wire logic mclk,
  output logic      rxdPin,
  input  wire logic txdPin
);
  logic [6:0] rxq[$];
  logic [6:0] c;
  initial rxdPin = 1'b1;
  // start, seven bits lsb first, even parity unless flipped, stop
  task automatic sendChar(input logic [6:0] ch, input logic flip = 1'b0);
    logic [9:0] f;
    f = {1'b1, (^ch) ^ flip, ch, 1'b0};
    for (int b = 0; b < 10; b++) begin
      @(negedge mclk) rxdPin = f[b];
      repeat (7) @(negedge mclk);
    end
  endtask
  // sample mid bit; the bench only starts a telegram once a reply is over
  always begin
    @(negedge txdPin);
    repeat (4) @(posedge mclk);
    for (int b = 0; b < 7; b++) begin
      repeat (8) @(posedge mclk);
      c[b] = txdPin;
    end
    repeat (16) @(posedge mclk);
    rxq.push_back(c);
  end
endmodule

/* File: testbench/serial_bus_slave_telegram_test.sv */
// serial_bus_slave_telegram_test: telegram rows, then apply and timeout cases
// assumes BIT_CYCLES 8 at baud setting 5, station 3, checksum chosen per row
`timescale 1ns/1ps
module serial_bus_slave_telegram_test;
  import sbst_pkg::*;
  typedef struct {
    logic [1:0] mode; logic ck; logic [79:0] req; int nReq; logic [55:0] rep; int nRep;
  } sbst_row_type;
  logic        ckSel = 1'b0, txdDrive;
  logic [4:0]  stAddr = 5'h00;
  logic [6:0]  st1 = 7'h21, st2 = 7'h22;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        rxdPin, txdPin, nvCommit, applyValid, computerStandby, remoteComputerStandby;
  logic [1:0]  mode = 2'h2;
  logic        toSel = 1'b0, sbyIn = 1'b0, cStart = 1'b0, cEnd = 1'b0, stValid = 1'b0;
  logic [15:0] stData = 16'h0000, applyData, paramRdData;
  logic [7:0]  paramRdAddr, applyAddr;
  int          nFail = 0, numChecks = 0, cyc = 0;
  // STX, station, ctrl, address, data, ETX
  sbst_row_type rows[10] = '{
    '{2'h2, 1'b0, 80'h026303, 3, 56'h0243212203, 5},
    '{2'h2, 1'b0, 80'h024361313003, 6, 56'h02434135313003, 7},
    '{2'h2, 1'b0, 80'h024361363803, 6, 56'h02433132333403, 7},
    '{2'h2, 1'b0, 80'h024361363903, 6, 56'h02433536373803, 7},
    '{2'h2, 1'b0, 80'h024561313003, 6, 56'h0, 0},
    '{2'h0, 1'b0, 80'h02434131303030303103, 10, 56'h15, 1},
    '{2'h2, 1'b0, 80'h024360313003, 6, 56'h15, 1},
    '{2'h2, 1'b1, 80'h02630360, 4, 56'h024321220343, 6},
    '{2'h2, 1'b1, 80'h02630361, 4, 56'h15, 1},
    '{2'h2, 1'b0, 80'h02434136353030383003, 10, 56'h024303, 3}};
  assign paramRdData = {8'ha5, paramRdAddr};
  initial forever #5 mclk = ~mclk;
  sbst_master_model i_sbst_master_model (.mclk(mclk), .rxdPin(rxdPin), .txdPin(txdPin));
  sbst_telegram_slave #(.BIT_CYCLES(8), .TIMEOUT_CYCLES(2000)) i_sbst_telegram_slave (
    .mclk(mclk), .nrst(nrst), .rxdPin(rxdPin), .txdPin(txdPin), .txdDrive(txdDrive),
    .baudSelectSwitch(3'h5), .interfaceModeSwitch(mode), .stationNumberSwitch(5'h03),
    .timeoutSelectSwitch(toSel), .checksumSwitch(ckSel), .standbyInput(sbyIn),
    .statusByteOne(st1), .statusByteTwo(st2), .cycleStart(cStart), .cycleEnd(cEnd),
    .stageWrValid(stValid), .stageWrAddr(stAddr), .stageWrData(stData),
    .paramRdAddr(paramRdAddr), .paramRdData(paramRdData), .applyValid(applyValid),
    .applyAddr(applyAddr), .applyData(applyData), .nvCommit(nvCommit),
    .computerStandby(computerStandby), .remoteComputerStandby(remoteComputerStandby));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling well above the roughly 17000 cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 25000) begin
      nFail++;
      printVerdict();
    end
  end
  initial begin
    repeat (16) @(negedge mclk);
    chk(16'(txdPin), 16'h1);
    chk(16'(txdDrive), 16'h0);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    stValid = 1'b1;
    stData = 16'h1234;
    @(negedge mclk);
    stAddr = 5'h01;
    stData = 16'h5678;
    @(negedge mclk);
    stValid = 1'b0;
    cEnd = 1'b1;
    @(negedge mclk);
    cEnd = 1'b0;
    for (int i = 0; i < 10; i++) begin
      mode = rows[i].mode;
      ckSel = rows[i].ck;
      i_sbst_master_model.rxq.delete();
      for (int k = 0; k < rows[i].nReq; k++)
        i_sbst_master_model.sendChar(rows[i].req[8*(rows[i].nReq-1-k) +: 7]);
      repeat (800) @(negedge mclk);
      chk(16'(i_sbst_master_model.rxq.size()), 16'(rows[i].nRep));
      for (int k = 0; k < i_sbst_master_model.rxq.size() && k < rows[i].nRep; k++)
        chk(16'(i_sbst_master_model.rxq[k]), 16'(rows[i].rep[8*(rows[i].nRep-1-k) +: 7]));
      $display("test %0d done", i);
    end
    // a parity fault in the body is refused while the master is still busy
    i_sbst_master_model.rxq.delete();
    i_sbst_master_model.sendChar(CHAR_STX);
    i_sbst_master_model.sendChar(7'h43);
    i_sbst_master_model.sendChar(7'h61, 1'b1);
    repeat (20) @(negedge mclk);
    chk(16'(txdDrive), 16'h1);
    repeat (200) @(negedge mclk);
    chk(16'(i_sbst_master_model.rxq.size()), 16'h1);
    chk(16'(i_sbst_master_model.rxq[0]), 16'(CHAR_NAK));
    chk(16'(txdDrive), 16'h0);
    $display("test parity done");
    cStart = 1'b1;
    @(negedge mclk);
    cStart = 1'b0;
    for (int w = 0; w < 10 && applyValid !== 1'b1; w++) @(negedge mclk);
    chk(16'(applyValid), 16'h1);
    chk(16'(applyAddr), 16'h65);
    chk(applyData, 16'h0080);
    chk(16'(nvCommit), 16'h0);
    repeat (3) @(negedge mclk);
    chk(16'(computerStandby), 16'h1);
    $display("test apply done");
    for (int k = 0; k < 10; k++)
      i_sbst_master_model.sendChar(rows[5].req[8*(9-k) +: 7]);
    repeat (800) @(negedge mclk);
    cStart = 1'b1;
    @(negedge mclk);
    cStart = 1'b0;
    @(negedge mclk);
    chk(16'(applyAddr), 16'h10);
    chk(applyData, 16'h0001);
    chk(16'(nvCommit), 16'h1);
    $display("test commit done");
    toSel = 1'b1;
    repeat (2100) @(negedge mclk);
    chk(16'(remoteComputerStandby), 16'h0);
    chk(16'(computerStandby), 16'h0);
    sbyIn = 1'b1;
    repeat (4) @(negedge mclk);
    chk(16'(computerStandby), 16'h1);
    $display("test timeout done");
    printVerdict();
  end
endmodule
